// ### logic/pio_pkg.sv
`default_nettype none
package pio_pkg;

    // Bus geometry of the internal register access
    localparam int PIO_ADDR_W = 16;
    localparam int PIO_DATA_W = 8;
    localparam int PIO_PORT_W = 8;
    localparam int PIO_CHSEL_W = 5;

    // Register addresses
    localparam logic [PIO_ADDR_W-1:0] PIO_ADDR_KB_DATA = 16'h0000;
    localparam logic [PIO_ADDR_W-1:0] PIO_ADDR_AN_DATA = 16'h0001;
    localparam logic [PIO_ADDR_W-1:0] PIO_ADDR_KB_DIR = 16'h0004;
    localparam logic [PIO_ADDR_W-1:0] PIO_ADDR_AN_DIR = 16'h0005;
    localparam logic [PIO_ADDR_W-1:0] PIO_ADDR_KB_PUE = 16'h000d;

    // Values after reset, and the read value of unmapped addresses
    localparam logic [PIO_PORT_W-1:0] PIO_DIR_RESET = 8'h00;
    localparam logic [PIO_PORT_W-1:0] PIO_PUE_RESET = 8'h00;
    localparam logic [PIO_DATA_W-1:0] PIO_RDATA_RESET = 8'h00;
    localparam logic [PIO_DATA_W-1:0] PIO_UNMAPPED_READ = 8'h00;

    // Channel codes below this one land on the analog-capable port
    localparam logic [PIO_CHSEL_W-1:0] PIO_CHAN_PORT_LIMIT = 5'h08;

    // Value seen by software: latch for outputs, pin level for inputs
    function automatic logic [PIO_PORT_W-1:0] pio_pin_read(
        input logic [PIO_PORT_W-1:0] dir,
        input logic [PIO_PORT_W-1:0] latch,
        input logic [PIO_PORT_W-1:0] pin
    );
        pio_pin_read = (dir & latch) | (~dir & pin);
    endfunction : pio_pin_read

    // One-hot pin select from the converter channel code
    function automatic logic [PIO_PORT_W-1:0] pio_chan_onehot(
        input logic [PIO_CHSEL_W-1:0] chan
    );
        logic [PIO_PORT_W-1:0] hot;
        hot = 8'h00;
        if (chan < PIO_CHAN_PORT_LIMIT)
        begin
            hot[chan[2:0]] = 1'b1;
        end
        pio_chan_onehot = hot;
    endfunction : pio_chan_onehot

endpackage : pio_pkg
`default_nettype wire

// ### logic/pio_port.sv
`timescale 1ns/1ps
`default_nettype none
module pio_port #(
    parameter int W = 8,
    parameter bit HAS_PULLUP = 1'b1
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic data_we,
    input wire logic dir_we,
    input wire logic pue_we,
    input wire logic [W-1:0] wdata,
    input wire logic [W-1:0] force_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_pullup,
    output logic [W-1:0] latch,
    output logic [W-1:0] dir,
    output logic [W-1:0] pue,
    output logic [W-1:0] read_val
);
    import pio_pkg::*;

    logic [W-1:0] next_latch;
    logic [W-1:0] next_dir;
    logic [W-1:0] next_pue;
    logic [W-1:0] dir_eff;

    // Width beyond one data byte cannot be reached by the bus
    if (W < 1 || W > PIO_DATA_W)
    begin : g_bad_width
        $error("pio_port width must be 1 to 8");
    end

    always_comb
    begin
        next_latch = data_we ? wdata : latch;
        next_dir = dir_we ? wdata : dir;
        next_pue = (pue_we && HAS_PULLUP) ? wdata : pue;
    end

    // latch kept over reset, so no reset branch
    always_ff @(posedge clk_sys)
    begin
        latch <= next_latch;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dir <= PIO_DIR_RESET[W-1:0];
            pue <= PIO_PUE_RESET[W-1:0];
        end
        else
        begin
            dir <= next_dir;
            pue <= next_pue;
        end
    end

    always_comb
    begin
        dir_eff = dir & ~force_in;
        pin_oe = dir_eff;
        pin_out = latch & dir_eff;
        pin_pullup = HAS_PULLUP ? (pue & ~dir_eff) : '0;
        read_val = (dir_eff & latch) | (~dir_eff & pin_in);
    end

endmodule : pio_port
`default_nettype wire

// ### logic/pio_ports_ab.sv
`timescale 1ns/1ps
`default_nettype none
module pio_ports_ab (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [pio_pkg::PIO_ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [pio_pkg::PIO_DATA_W-1:0] bus_wdata,
    output logic [pio_pkg::PIO_DATA_W-1:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic [pio_pkg::PIO_PORT_W-1:0] kb_pin_in,
    output logic [pio_pkg::PIO_PORT_W-1:0] kb_pin_out,
    output logic [pio_pkg::PIO_PORT_W-1:0] kb_pin_oe,
    output logic [pio_pkg::PIO_PORT_W-1:0] kb_pin_pullup,
    input wire logic [pio_pkg::PIO_PORT_W-1:0] an_pin_in,
    output logic [pio_pkg::PIO_PORT_W-1:0] an_pin_out,
    output logic [pio_pkg::PIO_PORT_W-1:0] an_pin_oe,
    input wire logic [pio_pkg::PIO_PORT_W-1:0] keyboard_pin_irq_enables,
    output logic [pio_pkg::PIO_PORT_W-1:0] keyboard_inputs,
    input wire logic [pio_pkg::PIO_CHSEL_W-1:0] converter_channel_select,
    output logic [pio_pkg::PIO_PORT_W-1:0] analog_inputs
);
    import pio_pkg::*;

    logic hit_kb_data;
    logic hit_an_data;
    logic hit_kb_dir;
    logic hit_an_dir;
    logic hit_kb_pue;
    logic [PIO_PORT_W-1:0] an_force;
    logic [PIO_PORT_W-1:0] kb_latch;
    logic [PIO_PORT_W-1:0] kb_dir;
    logic [PIO_PORT_W-1:0] kb_pue;
    logic [PIO_PORT_W-1:0] kb_read;
    logic [PIO_PORT_W-1:0] an_latch;
    logic [PIO_PORT_W-1:0] an_dir;
    logic [PIO_PORT_W-1:0] an_read;
    logic [PIO_PORT_W-1:0] an_pullup_unused;
    logic [PIO_PORT_W-1:0] an_pue_unused;
    logic [PIO_DATA_W-1:0] next_bus_rdata;
    logic next_bus_rvalid;
    logic [PIO_PORT_W-1:0] next_keyboard_inputs;
    logic [PIO_PORT_W-1:0] next_analog_inputs;

    // Address decode of the five registers
    // Full 16-bit compare, so no alias of a register answers
    always_comb
    begin
        hit_kb_data = (bus_addr == PIO_ADDR_KB_DATA);
        hit_an_data = (bus_addr == PIO_ADDR_AN_DATA);
        hit_kb_dir = (bus_addr == PIO_ADDR_KB_DIR);
        hit_an_dir = (bus_addr == PIO_ADDR_AN_DIR);
        hit_kb_pue = (bus_addr == PIO_ADDR_KB_PUE);
    end

    always_comb
    begin
        an_force = pio_chan_onehot(converter_channel_select);
    end

    pio_port #(
        .W(PIO_PORT_W),
        .HAS_PULLUP(1'b1)
    ) u_kb_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .data_we(bus_wr && hit_kb_data),
        .dir_we(bus_wr && hit_kb_dir),
        .pue_we(bus_wr && hit_kb_pue),
        .wdata(bus_wdata),
        .force_in('0),
        .pin_in(kb_pin_in),
        .pin_out(kb_pin_out),
        .pin_oe(kb_pin_oe),
        .pin_pullup(kb_pin_pullup),
        .latch(kb_latch),
        .dir(kb_dir),
        .pue(kb_pue),
        .read_val(kb_read)
    );

    pio_port #(
        .W(PIO_PORT_W),
        .HAS_PULLUP(1'b0)
    ) u_an_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .data_we(bus_wr && hit_an_data),
        .dir_we(bus_wr && hit_an_dir),
        .pue_we(1'b0),
        .wdata(bus_wdata),
        .force_in(an_force),
        .pin_in(an_pin_in),
        .pin_out(an_pin_out),
        .pin_oe(an_pin_oe),
        .pin_pullup(an_pullup_unused),
        .latch(an_latch),
        .dir(an_dir),
        .pue(an_pue_unused),
        .read_val(an_read)
    );

    // read data mux, pins captured on the read edge itself
    // Data then held until the next read, for a late master
    always_comb
    begin
        next_bus_rvalid = bus_rd;
        next_bus_rdata = bus_rdata;
        if (bus_rd)
        begin
            if (hit_kb_data)
            begin
                next_bus_rdata = kb_read;
            end
            else if (hit_an_data)
            begin
                next_bus_rdata = an_read;
            end
            else if (hit_kb_dir)
            begin
                next_bus_rdata = kb_dir;
            end
            else if (hit_an_dir)
            begin
                next_bus_rdata = an_dir;
            end
            else if (hit_kb_pue)
            begin
                next_bus_rdata = kb_pue;
            end
            else
            begin
                next_bus_rdata = PIO_UNMAPPED_READ;
            end
        end
    end

    // only enabled pins reach the keyboard interrupt logic
    always_comb
    begin
        next_keyboard_inputs = kb_pin_in & keyboard_pin_irq_enables;
        next_analog_inputs = an_pin_in & an_force;
    end

    // Registered outputs toward bus and neighbour modules
    // Registered so neighbours never see a pin glitch directly
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_rdata <= PIO_RDATA_RESET;
            bus_rvalid <= 1'b0;
            keyboard_inputs <= '0;
            analog_inputs <= '0;
        end
        else
        begin
            bus_rdata <= next_bus_rdata;
            bus_rvalid <= next_bus_rvalid;
            keyboard_inputs <= next_keyboard_inputs;
            analog_inputs <= next_analog_inputs;
        end
    end

    // Checks on direction reset
    a_dir_reset_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (kb_dir == PIO_DIR_RESET))
        else $error("keyboard direction not cleared by reset");
    a_an_dir_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (an_dir == PIO_DIR_RESET) && (an_pin_oe == '0))
        else $error("analog direction not cleared by reset");

    // Output buffers and pullups
    a_kb_drive_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        (kb_pin_oe == kb_dir) && ((kb_pin_out & kb_pin_oe) == (kb_latch & kb_dir)))
        else $error("keyboard pin not driving latch per direction");
    a_pullup_off_out: assert property (@(posedge clk_sys) disable iff (!resetn)
        (kb_pin_pullup & kb_pin_oe) == '0)
        else $error("pullup left on for output pin");
    a_pullup_needs_en: assert property (@(posedge clk_sys) disable iff (!resetn)
        (kb_pin_pullup == (kb_pue & ~kb_dir)))
        else $error("pullup does not follow enable and direction");
    a_pue_write_take: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_wr && hit_kb_pue) |=> (kb_pue == $past(bus_wdata)))
        else $error("pullup enable write lost");

    // Data latch and readback
    a_latch_write_take: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_wr && hit_kb_data) |=> (kb_latch == $past(bus_wdata)))
        else $error("keyboard latch write lost");
    a_an_latch_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_wr && hit_an_data) |=> (an_latch == $past(bus_wdata)))
        else $error("analog latch write lost");
    a_kb_read_value: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_kb_data) |=>
        bus_rvalid && (bus_rdata == pio_pin_read($past(kb_dir), $past(kb_latch), $past(kb_pin_in))))
        else $error("keyboard data read wrong");
    a_kb_read_input: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_kb_data && (kb_dir == '0)) |=> (bus_rdata == $past(kb_pin_in)))
        else $error("input bits do not read the pin");
    a_an_read_value: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_an_data) |=>
        (bus_rdata == pio_pin_read($past(an_dir & ~an_force), $past(an_latch), $past(an_pin_in))))
        else $error("analog data read wrong");
    a_read_one_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
        bus_rd |=> bus_rvalid ##1 (bus_rvalid == $past(bus_rd)))
        else $error("read answer not one cycle later");

    // Analog override and keyboard gating
    a_analog_force_in: assert property (@(posedge clk_sys) disable iff (!resetn)
        ((an_pin_oe & an_force) == '0) && $onehot0(an_force))
        else $error("selected analog pin still driven");
    a_kbi_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 ((keyboard_inputs & ~$past(keyboard_pin_irq_enables)) == '0))
        else $error("disabled keyboard pin reached interrupt input");

    // Register writes land and read back as stored
    a_kb_dir_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_wr && hit_kb_dir) |=> (kb_dir == $past(bus_wdata)))
        else $error("keyboard direction write lost");
    a_an_dir_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_wr && hit_an_dir) |=> (an_dir == $past(bus_wdata)))
        else $error("analog direction write lost");
    a_kb_dir_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_kb_dir) |=> (bus_rdata == $past(kb_dir)))
        else $error("keyboard direction read wrong");
    a_pue_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_kb_pue) |=> (bus_rdata == $past(kb_pue)))
        else $error("pullup enable read wrong");

    // Data reads with all bits one way, so a swapped mux shows up
    a_kb_read_output: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_kb_data && (kb_dir == '1)) |=> (bus_rdata == $past(kb_latch)))
        else $error("keyboard output bits do not read the latch");
    a_an_read_output: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_an_data && ((an_dir & ~an_force) == '1)) |=> (bus_rdata == $past(an_latch)))
        else $error("analog output bits do not read the latch");
    a_an_read_input: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bus_rd && hit_an_data && (an_dir == '0)) |=> (bus_rdata == $past(an_pin_in)))
        else $error("analog input bits do not read the pin");

    // Read answer: one pulse, data held until the next read
    a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
        bus_rvalid |-> $past(bus_rd))
        else $error("read answer without a read");
    a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
        !bus_rd |=> (bus_rdata == $past(bus_rdata)))
        else $error("read data changed without a read");

    // Analog pins: no pullup, quiet when not driven, converter copy
    a_an_drive_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        (an_pin_oe == (an_dir & ~an_force)) && (an_pin_out == (an_latch & an_pin_oe)))
        else $error("analog pin not driving latch per direction");
    a_an_no_pullup: assert property (@(posedge clk_sys) disable iff (!resetn)
        (an_pullup_unused == '0) && (an_pue_unused == '0))
        else $error("analog port shows a pullup");
    a_an_quiet_inputs: assert property (@(posedge clk_sys) disable iff (!resetn)
        (an_pin_out & ~an_pin_oe) == '0)
        else $error("analog pin value leaks on an input");
    a_an_inputs_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        resetn |=> (analog_inputs == $past(an_pin_in & an_force)))
        else $error("converter input does not follow selected pin");

    // Keyboard side: registered copy of enabled pins, quiet inputs
    a_kb_inputs_value: assert property (@(posedge clk_sys) disable iff (!resetn)
        resetn |=> (keyboard_inputs == $past(kb_pin_in & keyboard_pin_irq_enables)))
        else $error("keyboard input copy wrong");
    a_kb_quiet_inputs: assert property (@(posedge clk_sys) disable iff (!resetn)
        (kb_pin_out & ~kb_pin_oe) == '0)
        else $error("keyboard pin value leaks on an input");

    // Held reset keeps direction, pullup enable and read registers cleared; not gated by reset on purpose
    a_reset_quiet: assert property (@(posedge clk_sys)
        (!resetn ##1 !resetn) |->
        (kb_dir == '0) && (an_dir == '0) && (kb_pue == '0) && !bus_rvalid && (bus_rdata == '0))
        else $error("registers not held cleared in reset");

endmodule : pio_ports_ab
`default_nettype wire

// ### verification/pio_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module pio_pins_model (
    input wire logic clk_sys,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] kb_out,
    input wire logic [7:0] kb_oe,
    input wire logic [7:0] kb_pu,
    input wire logic [7:0] an_out,
    input wire logic [7:0] an_oe,
    output logic [7:0] kb_pin,
    output logic [7:0] an_pin
);
    logic [7:0] drift = 8'h5a;
    // Floating lines change for five cycles from 8'h5a, then stay at 8'hff
    always @(posedge clk_sys)
    begin
        drift <= ~drift ^ {drift[6:0], drift[7]};
    end
    // device drive, then outside drive, then pullup or float
    assign kb_pin = (kb_oe & kb_out) | (~kb_oe & ext_en & ext_val) | (~kb_oe & ~ext_en & (kb_pu | drift));
    assign an_pin = (an_oe & an_out) | (~an_oe & ext_en & ext_val) | (~an_oe & ~ext_en & drift);
endmodule : pio_pins_model
`default_nettype wire

// ### verification/pio_ports_ab_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pio_ports_ab_tb;
    import pio_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] keyboard_pin_irq_enables = 8'h00;
    logic [4:0] converter_channel_select = 5'h1f;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] bus_rdata, kb_pin_in, kb_pin_out, kb_pin_oe, kb_pin_pullup;
    logic [7:0] an_pin_in, an_pin_out, an_pin_oe, keyboard_inputs, analog_inputs;
    logic bus_rvalid;
    logic [7:0] klat, alat, kdir = 8'h00, adir = 8'h00, pue = 8'h00, kb_prev, an_prev;
    logic [15:0] addrs [7] = '{16'h0000, 16'h0001, 16'h0004, 16'h0005, 16'h000d, 16'h0002, 16'h0080};
    bit chk_on = 1'b0;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    pio_ports_ab uut (.clk_sys, .resetn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_rvalid,
        .kb_pin_in, .kb_pin_out, .kb_pin_oe, .kb_pin_pullup, .an_pin_in, .an_pin_out, .an_pin_oe,
        .keyboard_pin_irq_enables, .keyboard_inputs, .converter_channel_select, .analog_inputs);

    pio_pins_model pins (.clk_sys, .ext_en, .ext_val, .kb_out(kb_pin_out), .kb_oe(kb_pin_oe),
        .kb_pu(kb_pin_pullup), .an_out(an_pin_out), .an_oe(an_pin_oe), .kb_pin(kb_pin_in), .an_pin(an_pin_in));

    // Converter code to pin mask, codes of 8 and up pick none
    function automatic logic [7:0] onehot(input logic [4:0] c);
        onehot = (c < 5'h08) ? (8'h01 << c[2:0]) : 8'h00;
    endfunction : onehot

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Unmapped writes leave the model untouched
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        case (a)
            PIO_ADDR_KB_DATA: klat = d;
            PIO_ADDR_AN_DATA: alat = d;
            PIO_ADDR_KB_DIR: kdir = d;
            PIO_ADDR_AN_DIR: adir = d;
            PIO_ADDR_KB_PUE: pue = d;
            default: ;
        endcase
    endtask : wr

    // Expected value is taken from the pins just before the sampling edge
    task automatic rd(input logic [15:0] a);
        logic [7:0] e;
        logic [7:0] ad;
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(negedge clk_sys);
        ad = adir & ~onehot(converter_channel_select);
        case (a)
            PIO_ADDR_KB_DATA: e = (kdir & klat) | (~kdir & kb_pin_in);
            PIO_ADDR_AN_DATA: e = (ad & alat) | (~ad & an_pin_in);
            PIO_ADDR_KB_DIR: e = kdir;
            PIO_ADDR_AN_DIR: e = adir;
            PIO_ADDR_KB_PUE: e = pue;
            default: e = 8'h00;
        endcase
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk("rvalid", 8'h01, {7'h00, bus_rvalid});
        chk($sformatf("rdata %h", a), e, bus_rdata);
    endtask : rd

    // Pin side watched every cycle while chk_on is set, against the register model
    always @(negedge clk_sys)
    begin
        if (chk_on)
        begin
            chk("kb_oe", kdir, kb_pin_oe);
            chk("kb_out", kdir & klat, kb_pin_out & kdir);
            chk("kb_pullup", pue & ~kdir, kb_pin_pullup);
            chk("an_oe", adir & ~onehot(converter_channel_select), an_pin_oe);
            chk("an_out", adir & ~onehot(converter_channel_select) & alat, an_pin_out);
            chk("kb_inputs", kb_prev, keyboard_inputs);
            chk("an_inputs", an_prev, analog_inputs);
        end
        kb_prev = kb_pin_in & keyboard_pin_irq_enables;
        an_prev = an_pin_in & onehot(converter_channel_select);
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            summarize();
        end
    end

    initial
    begin
        void'($urandom(72));
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(PIO_ADDR_KB_DIR);
        rd(PIO_ADDR_AN_DIR);
        rd(PIO_ADDR_KB_PUE);
        // latches written before any pin turns output
        wr(PIO_ADDR_KB_DATA, 8'($urandom));
        wr(PIO_ADDR_AN_DATA, 8'($urandom));
        chk_on = 1'b1;
        repeat (300)
        begin
            @(posedge clk_sys);
            ext_en <= 8'($urandom);
            ext_val <= 8'($urandom);
            keyboard_pin_irq_enables <= 8'($urandom);
            converter_channel_select <= 5'($urandom_range(0, 12));
            if ($urandom_range(0, 1) == 1)
                wr(addrs[$urandom_range(0, 6)], 8'($urandom));
            else
                rd(addrs[$urandom_range(0, 6)]);
        end
        // Second reset mid-run: direction cleared, latches kept
        chk_on = 1'b0;
        @(posedge clk_sys);
        resetn <= 1'b0;
        converter_channel_select <= 5'h1f;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        kdir = 8'h00;
        adir = 8'h00;
        pue = 8'h00;
        rd(PIO_ADDR_KB_DIR);
        rd(PIO_ADDR_AN_DIR);
        chk_on = 1'b1;
        rd(PIO_ADDR_KB_DATA);
        rd(PIO_ADDR_AN_DATA);
        wr(PIO_ADDR_KB_DIR, 8'hff);
        wr(PIO_ADDR_AN_DIR, 8'hff);
        rd(PIO_ADDR_KB_DATA);
        rd(PIO_ADDR_AN_DATA);
        summarize();
    end
endmodule : pio_ports_ab_tb
`default_nettype wire
